// ### core/ptc_cfg.svh
// Bit positions and reset values for the paper tape controller.
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH

// ----------------------------------------
// Status byte bit positions
// ----------------------------------------
`define PTC_ST_OVERRUN      3'h0
`define PTC_ST_NO_MOTION    3'h3
`define PTC_ST_BUF_WAIT     3'h4
`define PTC_ST_ATTENTION    3'h5
`define PTC_ST_UNAVAIL      3'h7

// ----------------------------------------
// Command byte bit positions
// ----------------------------------------
`define PTC_CMD_INT_DISABLE 3'h0
`define PTC_CMD_INT_ENABLE  3'h1
`define PTC_CMD_STOP        3'h2
`define PTC_CMD_RUN         3'h3
`define PTC_CMD_STEP        3'h4
`define PTC_CMD_CONT        3'h5
`define PTC_CMD_WRITE_SEL   3'h6
`define PTC_CMD_READ_SEL    3'h7

// ----------------------------------------
// Reset values and synchroniser depth
// ----------------------------------------
`define PTC_RST_BYTE        8'h00
`define PTC_RST_STATUS      8'h38
`define PTC_SYNC_STAGES     3

`endif

// ### core/ptc_ctrl.sv
// Status and command logic of the paper tape reader/punch controller.
`default_nettype none
`include "ptc_cfg.svh"

module ptc_ctrl (
	// Clock and processor clear
	input  wire logic             core_clk,
	input  wire logic             rstn,
	// Processor programmed byte transfers
	input  wire logic             cmd_wr,
	input  wire logic [7:0]       cmd_byte,
	input  wire logic             data_rd,
	input  wire logic             data_wr,
	input  wire logic [7:0]       wr_byte,
	output logic      [7:0]       rd_byte,
	output logic      [7:0]       status_byte,
	output logic                  irq,
	// Tape mechanism pins
	input  wire ptc_pkg::ptc_pins_t mech_pins,
	output logic                  reader_drive,
	output logic                  punch_strobe,
	output logic      [7:0]       punch_char,
	output logic                  punch_motor_cmd
);

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	ptc_pkg::ptc_pins_t pins;
	logic               strobe_d;
	logic               punch_ready_d;

	ptc_sync #(
		.WIDTH($bits(ptc_pkg::ptc_pins_t))
	) u_sync (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.pin_in    (mech_pins),
		.level_out (pins)
	);

	// ----------------------------------------
	// Control state
	// ----------------------------------------
	ptc_pkg::ptc_dir_t dir;
	ptc_pkg::ptc_cmd_t cmd;
	logic       int_en;
	logic       run_mode;
	logic       step_mode;
	logic       cont_mode;
	logic       stop_pending;
	logic       buf_full;
	logic [7:0] char_buf;
	logic       overrun;
	logic       no_motion;
	logic       punch_busy;

	assign cmd = ptc_pkg::ptc_cmd_t'(cmd_byte);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire is_read     = (dir == ptc_pkg::PTC_DIR_READ);
	wire is_write    = (dir == ptc_pkg::PTC_DIR_WRITE);
	wire char_arrive = is_read && pins.reader_strobe && !strobe_d;
	// Only a punch cycle in flight can complete, so the ready pin settling after reset is ignored.
	wire punch_done  = is_write && punch_busy && pins.punch_ready && !punch_ready_d;
	// A run cancels a stop that has not yet taken effect; within one byte stop wins.
	wire run_cmd     = cmd_wr && cmd.run && !cmd.stop;
	// Direction in force after this edge, so a run sent with write select powers the punch.
	wire sel_write   = !(cmd_wr && cmd.read_sel) && (is_write || (cmd_wr && cmd.write_sel));
	wire take_char   = is_read && data_rd && buf_full;
	wire put_char    = is_write && data_wr && !buf_full;
	wire unavail_rd  = !pins.reader_motor_on || pins.load_lever_load;
	wire unavail_wr  = !pins.punch_motor_on || !pins.remote_online
		|| pins.low_tape;
	wire unavailable = is_read ? unavail_rd : unavail_wr;

	// The tape moves while running (or finishing a stop) and the buffer allows it.
	wire next_drive  = is_read && (run_mode || stop_pending)
		&& (cont_mode || !buf_full || take_char);

	// A punch cycle begins once the mechanism is idle and available.
	wire start_punch = is_write && buf_full && !punch_busy && punch_motor_cmd
		&& pins.punch_ready && !unavail_wr;

	wire next_ovr    = is_read && (char_arrive && buf_full && !take_char
		|| (overrun && !(take_char || run_cmd)));

	wire stop_hit    = stop_pending && !run_cmd && (is_read ? char_arrive : punch_done);
	wire next_no_motion_flag   = is_read && (stop_hit || (no_motion && !run_cmd));

	wire buf_wait    = is_read ? !buf_full : buf_full;
	// Flags are masked by direction so a mode switch never shows a stale reader flag.
	wire ovr_flag    = is_read && overrun;
	wire no_motion_flag_flag   = is_read && no_motion;
	wire attention   = ovr_flag || no_motion_flag_flag;

	wire [7:0] next_status = {unavailable, 1'b0, attention, buf_wait,
		no_motion_flag_flag, 2'b00, ovr_flag};

	wire next_irq    = int_en && (is_read ? buf_full
		: (!buf_full && !punch_busy));

	wire next_int_en = (cmd_wr && cmd.int_disable) ? 1'b0
		: (cmd_wr && cmd.int_enable) ? 1'b1 : int_en;

	// Load wins over a simultaneous take so that no character is lost.
	wire next_full   = (char_arrive || put_char) ? 1'b1
		: (take_char || start_punch) ? 1'b0 : buf_full;

	// ----------------------------------------
	// Command register
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			dir       <= ptc_pkg::PTC_DIR_READ;
			run_mode  <= 1'b0;
			step_mode <= 1'b1;
			cont_mode <= 1'b0;
		end else if (cmd_wr) begin
			if (cmd.read_sel) begin
				dir <= ptc_pkg::PTC_DIR_READ;
			end else if (cmd.write_sel) begin
				dir <= ptc_pkg::PTC_DIR_WRITE;
			end
			if (cmd.stop) begin
				run_mode <= 1'b0;
			end else if (cmd.run) begin
				run_mode <= 1'b1;
			end
			if (cmd.cont) begin
				cont_mode <= 1'b1;
				step_mode <= 1'b0;
			end else if (cmd.step) begin
				cont_mode <= 1'b0;
				step_mode <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Stop sequencing
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			stop_pending <= 1'b0;
		end else if (cmd_wr && cmd.stop && run_mode) begin
			stop_pending <= 1'b1;
		end else if (stop_hit || (cmd_wr && cmd.run)) begin
			stop_pending <= 1'b0;
		end
	end

	// ----------------------------------------
	// Buffer and flags
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			int_en     <= 1'b0;
			buf_full   <= 1'b0;
			char_buf   <= `PTC_RST_BYTE;
			overrun    <= 1'b0;
			no_motion  <= 1'b1;
			strobe_d   <= 1'b0;
			punch_ready_d <= 1'b0;
			punch_busy <= 1'b0;
		end else begin
			int_en     <= next_int_en;
			buf_full   <= next_full;
			overrun    <= next_ovr;
			no_motion  <= next_no_motion_flag;
			strobe_d   <= pins.reader_strobe;
			punch_ready_d <= pins.punch_ready;
			if (char_arrive) begin
				char_buf <= pins.reader_char;
			end else if (put_char) begin
				char_buf <= wr_byte;
			end
			if (start_punch) begin
				punch_busy <= 1'b1;
			end else if (punch_done || !is_write) begin
				punch_busy <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			status_byte     <= `PTC_RST_STATUS;
			rd_byte         <= `PTC_RST_BYTE;
			irq             <= 1'b0;
			reader_drive    <= 1'b0;
			punch_strobe    <= 1'b0;
			punch_char      <= `PTC_RST_BYTE;
			punch_motor_cmd <= 1'b0;
		end else begin
			status_byte  <= next_status;
			rd_byte      <= char_buf;
			irq          <= next_irq;
			reader_drive <= next_drive && !stop_hit;
			punch_strobe <= start_punch;
			if (start_punch) begin
				punch_char <= char_buf;
			end
			if (run_cmd && sel_write) begin
				punch_motor_cmd <= 1'b1;
			end else if (is_write && stop_hit) begin
				punch_motor_cmd <= 1'b0;
			end
		end
	end

endmodule : ptc_ctrl

`default_nettype wire

// ### core/ptc_pkg.sv
// Types shared by the paper tape controller files.
`default_nettype none

package ptc_pkg;

	typedef enum logic [1:0] {
		PTC_DIR_READ  = 2'b01,
		PTC_DIR_WRITE = 2'b10
	} ptc_dir_t;

	typedef struct packed {
		logic read_sel;
		logic write_sel;
		logic cont;
		logic step;
		logic run;
		logic stop;
		logic int_enable;
		logic int_disable;
	} ptc_cmd_t;

	typedef struct packed {
		logic [7:0] reader_char;
		logic       reader_strobe;
		logic       reader_motor_on;
		logic       load_lever_load;
		logic       punch_motor_on;
		logic       remote_online;
		logic       low_tape;
		logic       punch_ready;
	} ptc_pins_t;

endpackage : ptc_pkg

`default_nettype wire

// ### core/ptc_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`default_nettype none
`include "ptc_cfg.svh"

module ptc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rstn,
	// Pin side
	input  wire logic [WIDTH-1:0] pin_in,
	// Core side
	output logic      [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
	wire  [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level_out);

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			stage1    <= '0;
			stage2    <= '0;
			stage3    <= '0;
			level_out <= '0;
		end else begin
			stage1    <= pin_in;
			stage2    <= stage1;
			stage3    <= stage2;
			level_out <= next_level;
		end
	end

endmodule : ptc_sync

`default_nettype wire

// ### verif/ptc_ctrl_assertions.sv
// Concurrent checks on the controller's status, command and punch ports.
`default_nettype none
module ptc_ctrl_chk (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rstn,
	// Processor side
	input wire logic       cmd_wr,
	input wire logic [7:0] cmd_byte,
	input wire logic [7:0] status_byte,
	input wire logic       irq,
	// Mechanism side
	input wire logic       reader_drive,
	input wire logic       punch_strobe,
	input wire logic [7:0] punch_char
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_wsel;
		cmd_wr && cmd_byte[6] && !cmd_byte[7];
	endsequence
	sequence s_run;
		cmd_wr && cmd_byte[3] && !cmd_byte[2] ##1 !cmd_wr;
	endsequence
	property p_clear;
		$rose(rstn) |-> status_byte == 8'h38 && !irq && !reader_drive && !punch_strobe;
	endproperty
	property p_spare;
		(status_byte & 8'h46) == 8'h00;
	endproperty
	property p_attn;
		status_byte[5] == (status_byte[0] || status_byte[3]);
	endproperty
	property p_wclr;
		s_wsel |-> ##2 (status_byte & 8'h29) == 8'h00;
	endproperty
	property p_wdrv;
		s_wsel |-> ##2 !reader_drive;
	endproperty
	property p_run;
		s_run |-> ##1 !status_byte[3];
	endproperty
	property p_dis;
		cmd_wr && cmd_byte[0] |-> ##2 !irq;
	endproperty
	property p_pulse;
		punch_strobe |=> !punch_strobe;
	endproperty
	property p_pchar;
		$changed(punch_char) |-> punch_strobe;
	endproperty
	a_clear : assert property (p_clear) else $error("reset values wrong");
	a_spare : assert property (p_spare) else $error("spare status bit set");
	a_attn : assert property (p_attn) else $error("attention not or of flags");
	a_wclr : assert property (p_wclr) else $error("punch mode flags set");
	a_wdrv : assert property (p_wdrv) else $error("reader moves in punch mode");
	a_run : assert property (p_run) else $error("run left no-motion set");
	a_dis : assert property (p_dis) else $error("interrupt after disable");
	a_pulse : assert property (p_pulse) else $error("punch strobe too long");
	a_pchar : assert property (p_pchar) else $error("punch data moved alone");
endmodule : ptc_ctrl_chk

bind ptc_ctrl ptc_ctrl_chk ptc_ctrl_chk_i (.core_clk, .rstn, .cmd_wr, .cmd_byte,
	.status_byte, .irq, .reader_drive, .punch_strobe, .punch_char);
`default_nettype wire

// ### verif/ptc_mech_model.sv
// Tape mechanism stand-in: reader character source and punch head.
`default_nettype none
module ptc_mech_model (
	// Clock
	input  wire logic         core_clk,
	// Controller side
	input  wire logic         reader_drive,
	input  wire logic         punch_strobe,
	input  wire logic [7:0]   punch_char,
	// Bench side
	input  wire logic [4:0]   ctl,
	input  wire logic [4:0]   gap,
	output logic      [7:0]   sent,
	output logic      [7:0]   punched,
	// Mechanism pins
	output var ptc_pkg::ptc_pins_t mech_pins
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rc = 8'h00;
	logic       rs = 1'b0;
	logic       pr = 1'b1;
	assign mech_pins = {rc, rs, ctl, pr};
	// Data lines hold around the strobe, then show the inverse six cycles after it is released.
	always begin
		@(posedge core_clk);
		if (reader_drive) begin
			sent = 8'($urandom);
			rc <= sent;
			repeat (6) @(posedge core_clk);
			rs <= 1'b1;
			repeat (6) @(posedge core_clk);
			rs <= 1'b0;
			repeat (6) @(posedge core_clk);
			rc <= ~sent;
			repeat (gap) @(posedge core_clk);
		end
	end
	always begin
		@(posedge core_clk);
		if (punch_strobe) begin
			punched <= punch_char;
			pr <= 1'b0;
			repeat (gap + 8) @(posedge core_clk);
			pr <= 1'b1;
		end
	end
endmodule : ptc_mech_model
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the paper tape controller.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rstn = 0, cmd_wr = 0, data_rd = 0, data_wr = 0;
	logic [7:0] cmd_byte = 8'h00, wr_byte = 8'h00, rd_byte, status_byte, punch_char, sent, punched;
	logic       irq, reader_drive, punch_strobe, punch_motor_cmd;
	logic [4:0] ctl = 5'h16, gap = 5'h00;
	ptc_pkg::ptc_pins_t mech_pins;
	int         n_errors = 0, tests_run = 0, cyc = 0, k;
	always #10 core_clk = ~core_clk;
	ptc_ctrl ptc_ctrl_i (.core_clk, .rstn, .cmd_wr, .cmd_byte, .data_rd, .data_wr, .wr_byte,
		.rd_byte, .status_byte, .irq, .mech_pins, .reader_drive, .punch_strobe, .punch_char,
		.punch_motor_cmd);
	ptc_mech_model ptc_mech_model_i (.core_clk, .reader_drive, .punch_strobe, .punch_char,
		.ctl, .gap, .sent, .punched, .mech_pins);
	task summarize;
		if (n_errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task cmd(input logic [7:0] b);
		@(posedge core_clk);
		cmd_wr <= 1'b1;
		cmd_byte <= b;
		@(posedge core_clk);
		cmd_wr <= 1'b0;
		tick(2);
	endtask : cmd
	task rd_pulse;
		@(posedge core_clk);
		data_rd <= 1'b1;
		@(posedge core_clk);
		data_rd <= 1'b0;
		tick(2);
	endtask : rd_pulse
	task wr_pulse(input logic [7:0] b);
		@(posedge core_clk);
		data_wr <= 1'b1;
		wr_byte <= b;
		@(posedge core_clk);
		data_wr <= 1'b0;
		tick(3);
	endtask : wr_pulse
	function automatic logic exp_du(input logic wr, input logic [4:0] c);
		return wr ? (!c[2] || !c[1] || c[0]) : (!c[4] || c[3]);
	endfunction : exp_du
	task du_loop(input logic wr);
		repeat (4) begin
			@(posedge core_clk);
			ctl <= 5'($urandom);
			tick(8);
			chk(status_byte[7], exp_du(wr, ctl));
		end
	endtask : du_loop
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		void'($urandom(94));
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		chk(status_byte, 8'h38);
		gap = 5'($urandom_range(0, 12));
		cmd(8'h9a);
		for (k = 0; k < 400 && status_byte[4] !== 1'b0; k++) tick(1);
		tick(2);
		chk(rd_byte, sent);
		chk(status_byte, 8'h00);
		chk(irq, 1'b1);
		chk(reader_drive, 1'b0);
		rd_pulse();
		chk(status_byte[4], 1'b1);
		chk(reader_drive, 1'b1);
		cmd(8'ha8);
		for (k = 0; k < 600 && status_byte[0] !== 1'b1; k++) tick(1);
		chk(status_byte & 8'h21, 8'h21);
		cmd(8'h85);
		for (k = 0; k < 400 && status_byte[3] !== 1'b1; k++) tick(1);
		chk(status_byte & 8'h28, 8'h28);
		chk(irq, 1'b0);
		tick(30);
		chk(reader_drive, 1'b0);
		chk(rd_byte, sent);
		rd_pulse();
		chk(status_byte & 8'h39, 8'h38);
		du_loop(1'b0);
		ctl <= 5'h14;
		cmd(8'h4a);
		chk(status_byte & 8'h39, 8'h00);
		chk(punch_motor_cmd, 1'b1);
		wr_pulse(8'($urandom));
		chk(status_byte[4], 1'b1);
		@(posedge core_clk);
		ctl <= 5'h16;
		for (k = 0; k < 300 && irq !== 1'b1; k++) tick(1);
		chk(punched, wr_byte);
		chk(irq, 1'b1);
		cmd(8'h04);
		wr_pulse(8'($urandom));
		for (k = 0; k < 300 && irq !== 1'b1; k++) tick(1);
		chk(punched, wr_byte);
		chk(punch_motor_cmd, 1'b0);
		du_loop(1'b1);
		summarize();
	end
endmodule : tb
`default_nettype wire
